// ===== logic/zone_area_pkg.sv
// Constants, register map and types for the area select and zone output block
package zone_area_pkg;

	// =========================================================================
	// Timing
	localparam int CLK_HZ            = 25_000_000;
	localparam int MS_PER_S          = 1000;
	localparam int CYCLES_PER_MS     = CLK_HZ / MS_PER_S;
	localparam int SETTLE_DEFAULT_MS = 30;

	// =========================================================================
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_DELAY    = 8'h04;
	localparam logic [7:0] OFS_STATUS   = 8'h08;
	localparam logic [7:0] OFS_IRQ_STS  = 8'h0C;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
	localparam logic [7:0] OFS_PAT_LO   = 8'h20;
	localparam logic [7:0] OFS_PAT_HI   = 8'h3C;

	// =========================================================================
	// Field positions
	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_DUAL_BIT  = 2;
	localparam int CTRL_COUNT_LSB = 8;
	localparam int PAT_TYPE_LSB   = 0;
	localparam int PAT_AREA_LSB   = 8;
	localparam int STS_AREA_LSB   = 0;
	localparam int STS_VALID_BIT  = 8;
	localparam int STS_DUAL_BIT   = 9;
	localparam int STS_SAFE0_BIT  = 12;
	localparam int STS_SAFE1_BIT  = 13;
	localparam int STS_ALERT1_BIT = 14;
	localparam int STS_ALERT2_BIT = 15;

	localparam int IRQ_COMP  = 0;
	localparam int IRQ_RANGE = 1;
	localparam int IRQ_PROT1 = 2;
	localparam int IRQ_PROT2 = 3;
	localparam int IRQ_WARN1 = 4;
	localparam int IRQ_WARN2 = 5;
	localparam int IRQ_AREA  = 6;
	localparam int IRQ_W     = 7;

	// =========================================================================
	// Modes, limits and reset values
	typedef enum logic [1:0] {
		MODE_STD          = 2'b00,
		MODE_CONTACT      = 2'b01,
		MODE_MUTE_CONTACT = 2'b10,
		MODE_ENC          = 2'b11
	} opmode_t;

	typedef enum logic [1:0] {
		PAT_UNUSED  = 2'b00,
		PAT_STATIC  = 2'b01,
		PAT_ENCODER = 2'b10
	} pattern_t;

	localparam logic [2:0]  STD_PAIRS        = 3'h5;
	localparam logic [2:0]  CONTACT_PAIRS    = 3'h4;
	localparam logic [2:0]  MUTE_PAIRS_ONE   = 3'h2;
	localparam logic [2:0]  MUTE_PAIRS_DUAL  = 3'h1;
	localparam logic [2:0]  ENC_PAIRS        = 3'h3;
	localparam logic [5:0]  ENC_STATIC_AREAS = 6'h07;
	localparam logic [5:0]  MAX_AREAS        = 6'h20;
	localparam logic [15:0] DELAY_RST        = 16'(SETTLE_DEFAULT_MS);

	// =========================================================================
	// Seven segment codes, gfedcba
	localparam logic [5:0] DISP_TEN   = 6'h0A;
	localparam int         DISP_TENS  = 3;
	localparam logic [6:0] SEG_DASH   = 7'h40;
	localparam logic [6:0] SEG_BLANK  = 7'h00;
	localparam logic [9:0][6:0] SEG_DIGITS = {
		7'h6F, 7'h7F, 7'h07, 7'h7D, 7'h6D,
		7'h66, 7'h4F, 7'h5B, 7'h06, 7'h3F
	};

endpackage

// ===== logic/zone_area_select_logic.sv
// Area selection, zone to output mapping and register slave
// =============================================================================
// Functional notes
// - Up to 32 area sets, one active
// - One protection plus two warnings, or dual
// - Protection detection drives safety outputs off
// - Dual mode: pair0 zone one, pair1 zone two
// - Outside dual mode, warning detection turns matching warning output off
// - Warning outputs independent of safety outputs
// - Flag error on non-complementary input pair
// - Settling delay before area change, default 30ms
// - Five pairs, 32 areas in standard mode
// - Monitoring mode: four pairs, 16 areas
// - Muting mode: two pairs/4, dual one/2
// - Encoder mode: three pairs, 7 static, single
// - Encoder: 8 patterns, one encoder, 32 areas
// - Five pairs: binary, OFF is one, LSB first
// - Four pairs decode 16 areas likewise
// - Display active area number on seven segments
// - Three, two, one pairs decode 8, 4, 2
`timescale 1ns/1ps

module zone_area_select_logic
	import zone_area_pkg::*;
#(
	parameter int CYCLES_MS = CYCLES_PER_MS,
	parameter int PRE_W     = 15
)(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        clkEn,
	input  wire logic [4:0]  areaIn,
	input  wire logic [4:0]  areaInInv,
	input  wire logic        protDetect1,
	input  wire logic        protDetect2,
	input  wire logic        warnDetect1,
	input  wire logic        warnDetect2,
	input  wire logic [4:0]  encArea,
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	output logic             safeOutPair0A,
	output logic             safeOutPair0B,
	output logic             safeOutPair1A,
	output logic             safeOutPair1B,
	output logic             alertOutZone1,
	output logic             alertOutZone2,
	output logic      [6:0]  segTens,
	output logic      [6:0]  segUnits,
	output logic             irq
);

	// =========================================================================
	// State
	typedef struct packed {
		logic [9:0]            syncA;
		logic [9:0]            syncB;
		logic [9:0]            lastRaw;
		logic                  pending;
		logic [PRE_W-1:0]      preCnt;
		logic [15:0]           msCnt;
		logic                  areaValid;
		logic [4:0]            activeArea;
		opmode_t               mode;
		logic                  dual;
		logic [5:0]            areaCount;
		logic [15:0]           delayMs;
		logic [7:0][1:0]       patType;
		logic [7:0][4:0]       patArea;
		logic [IRQ_W-1:0]      irqSts;
		logic [IRQ_W-1:0]      irqMask;
		logic                  waitReq;
		logic [31:0]           readData;
		logic                  safe0a;
		logic                  safe0b;
		logic                  safe1a;
		logic                  safe1b;
		logic                  alert1;
		logic                  alert2;
		logic                  irqOut;
		logic [6:0]            segT;
		logic [6:0]            segU;
	} state_t;

	state_t st;
	state_t nx;

	logic             dualEff;
	logic [2:0]       pairs;
	logic [4:0]       usedMask;
	logic [4:0]       normS;
	logic [4:0]       invS;
	logic [9:0]       raw;
	logic             rawChanged;
	logic             compErr;
	logic [4:0]       code;
	logic [5:0]       modeAreas;
	logic [5:0]       limit;
	logic [4:0]       idx;
	logic             rangeOk;
	logic             hasEnc;
	logic             accept;
	logic             newValid;
	logic [IRQ_W-1:0] events;
	logic [IRQ_W-1:0] w1c;
	logic [31:0]      beMask;
	logic [31:0]      rdVal;
	logic [31:0]      ctrlWord;
	logic [31:0]      wordNew;
	logic [5:0]       dispNum;
	logic [5:0]       units;
	logic [1:0]       tens;
	logic [2:0]       patIdx;

	// =========================================================================
	// Next state
	always_comb begin
		nx = st;
		// Two flip-flop capture of the area select pins
		nx.syncA = {areaInInv, areaIn};
		nx.syncB = st.syncA;

		dualEff = st.dual && (st.mode != MODE_ENC);
		case (st.mode)
			MODE_STD:      pairs = STD_PAIRS;
			MODE_CONTACT:      pairs = CONTACT_PAIRS;
			MODE_MUTE_CONTACT: pairs = dualEff ? MUTE_PAIRS_DUAL
			                                   : MUTE_PAIRS_ONE;
			default:       pairs = ENC_PAIRS;
		endcase
		for (int i = 0; i < 5; i++) begin
			usedMask[i] = (3'(i) < pairs);
		end

		normS = st.syncB[4:0];
		invS  = st.syncB[9:5];
		raw   = {invS & usedMask, normS & usedMask};
		compErr = |(~(normS ^ invS) & usedMask);
		// OFF on the normal input is a one, first input is bit 0
		code = ~normS & usedMask;

		// Range check against mode and configured set count
		modeAreas = 6'h01 << pairs;
		limit = (modeAreas < st.areaCount) ? modeAreas : st.areaCount;
		idx = code;
		rangeOk = ({1'b0, code} < limit);
		hasEnc = 1'b0;
		patIdx = code[2:0];
		for (int p = 0; p < 8; p++) begin
			hasEnc = hasEnc || (st.patType[p] == PAT_ENCODER);
		end
		if (st.mode == MODE_ENC) begin
			// Pattern table maps each three bit code to an area source
			case (pattern_t'(st.patType[patIdx]))
				PAT_STATIC: begin
					idx = st.patArea[patIdx];
					rangeOk = ({1'b0, idx} < ENC_STATIC_AREAS) &&
					          ({1'b0, idx} < st.areaCount);
				end
				PAT_ENCODER: begin
					idx = encArea;
					rangeOk = ({1'b0, idx} < st.areaCount);
				end
				default: begin
					rangeOk = 1'b0;
				end
			endcase
			// Without any encoder pattern the setup itself is invalid
			rangeOk = rangeOk && hasEnc;
		end

		// Settling: a new input pattern must stand for the delay
		accept = 1'b0;
		rawChanged = (raw != st.lastRaw);
		if (rawChanged) begin
			nx.lastRaw = raw;
			nx.pending = 1'b1;
			nx.preCnt  = '0;
			nx.msCnt   = '0;
		end else if (st.pending) begin
			if (st.msCnt >= st.delayMs) begin
				accept     = 1'b1;
				nx.pending = 1'b0;
			end else if (st.preCnt == PRE_W'(CYCLES_MS - 1)) begin
				nx.preCnt = '0;
				nx.msCnt  = st.msCnt + 16'h0001;
			end else begin
				nx.preCnt = st.preCnt + PRE_W'(1);
			end
		end
		newValid = !compErr && rangeOk;
		if (accept) begin
			nx.areaValid = newValid;
			if (newValid) begin
				nx.activeArea = idx;
			end
		end

		// Zone outputs; invalid selection keeps safety outputs off
		nx.safe0a = st.areaValid && !protDetect1;
		nx.safe0b = st.areaValid && !protDetect1;
		nx.safe1a = st.areaValid &&
		            !(dualEff ? protDetect2 : protDetect1);
		nx.safe1b = st.areaValid &&
		            !(dualEff ? protDetect2 : protDetect1);
		// Warnings ignore area validity and the safety path entirely
		nx.alert1 = dualEff || !warnDetect1;
		nx.alert2 = dualEff || !warnDetect2;

		events = '0;
		events[IRQ_COMP]  = accept && compErr;
		events[IRQ_RANGE] = accept && !compErr && !rangeOk;
		events[IRQ_PROT1] = st.safe0a && !nx.safe0a;
		events[IRQ_PROT2] = dualEff && st.safe1a && !nx.safe1a;
		events[IRQ_WARN1] = st.alert1 && !nx.alert1;
		events[IRQ_WARN2] = st.alert2 && !nx.alert2;
		events[IRQ_AREA]  = accept && newValid &&
		                    (!st.areaValid || idx != st.activeArea);

		// Display shows area number counted from one
		dispNum = {1'b0, st.activeArea} + 6'h01;
		units = dispNum;
		tens  = '0;
		for (int t = 0; t < DISP_TENS; t++) begin
			if (units >= DISP_TEN) begin
				units = units - DISP_TEN;
				tens  = tens + 2'h1;
			end
		end
		if (st.areaValid) begin
			nx.segT = (tens == 2'h0) ? SEG_BLANK : SEG_DIGITS[tens];
			nx.segU = SEG_DIGITS[units[3:0]];
		end else begin
			nx.segT = SEG_DASH;
			nx.segU = SEG_DASH;
		end

		// Register read mux
		ctrlWord = '0;
		ctrlWord[CTRL_MODE_LSB +: 2]  = st.mode;
		ctrlWord[CTRL_DUAL_BIT]       = st.dual;
		ctrlWord[CTRL_COUNT_LSB +: 6] = st.areaCount;
		rdVal = '0;
		if (address == OFS_CTRL) begin
			rdVal = ctrlWord;
		end else if (address == OFS_DELAY) begin
			rdVal[15:0] = st.delayMs;
		end else if (address == OFS_STATUS) begin
			rdVal[STS_AREA_LSB +: 5] = st.activeArea;
			rdVal[STS_VALID_BIT]     = st.areaValid;
			rdVal[STS_DUAL_BIT]      = dualEff;
			rdVal[STS_SAFE0_BIT]     = st.safe0a;
			rdVal[STS_SAFE1_BIT]     = st.safe1a;
			rdVal[STS_ALERT1_BIT]    = st.alert1;
			rdVal[STS_ALERT2_BIT]    = st.alert2;
		end else if (address == OFS_IRQ_STS) begin
			rdVal[IRQ_W-1:0] = st.irqSts;
		end else if (address == OFS_IRQ_MASK) begin
			rdVal[IRQ_W-1:0] = st.irqMask;
		end else if (address >= OFS_PAT_LO && address <= OFS_PAT_HI) begin
			rdVal[PAT_TYPE_LSB +: 2] = st.patType[address[4:2]];
			rdVal[PAT_AREA_LSB +: 5] = st.patArea[address[4:2]];
		end

		// Avalon slave: fixed one wait state, the write lands on the
		// edge where waitrequest is sampled low
		for (int b = 0; b < 4; b++) begin
			beMask[b*8 +: 8] = {8{byteenable[b]}};
		end
		w1c = '0;
		wordNew = '0;
		nx.waitReq = 1'b1;
		if ((read || write) && st.waitReq) begin
			nx.waitReq  = 1'b0;
			nx.readData = rdVal;
		end
		if (write && !st.waitReq) begin
			wordNew = (rdVal & ~beMask) | (writedata & beMask);
			if (address == OFS_CTRL) begin
				nx.mode = opmode_t'(wordNew[CTRL_MODE_LSB +: 2]);
				nx.dual = wordNew[CTRL_DUAL_BIT];
				nx.areaCount = wordNew[CTRL_COUNT_LSB +: 6];
				nx.pending = 1'b1;
				// Limits may shrink: drop the old area until re-judged
				nx.areaValid = 1'b0;
			end else if (address == OFS_DELAY) begin
				nx.delayMs = wordNew[15:0];
			end else if (address == OFS_IRQ_STS) begin
				w1c = writedata[IRQ_W-1:0] & beMask[IRQ_W-1:0];
			end else if (address == OFS_IRQ_MASK) begin
				nx.irqMask = wordNew[IRQ_W-1:0];
			end else if (address >= OFS_PAT_LO &&
			             address <= OFS_PAT_HI) begin
				nx.patType[address[4:2]] = wordNew[PAT_TYPE_LSB +: 2];
				nx.patArea[address[4:2]] = wordNew[PAT_AREA_LSB +: 5];
				nx.pending = 1'b1;
			end
		end
		// Hardware set wins over a same-cycle software clear
		nx.irqSts = (st.irqSts & ~w1c) | events;
		nx.irqOut = |(st.irqSts & st.irqMask);
	end

	// =========================================================================
	// Registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			st           <= '0;
			st.lastRaw   <= '1;
			st.pending   <= 1'b1;
			st.mode      <= MODE_STD;
			st.areaCount <= MAX_AREAS;
			st.delayMs   <= DELAY_RST;
			st.waitReq   <= 1'b1;
			st.segT      <= SEG_DASH;
			st.segU      <= SEG_DASH;
		end else if (clkEn) begin
			st <= nx;
		end
	end

	assign readdata      = st.readData;
	assign waitrequest   = st.waitReq;
	assign safeOutPair0A = st.safe0a;
	assign safeOutPair0B = st.safe0b;
	assign safeOutPair1A = st.safe1a;
	assign safeOutPair1B = st.safe1b;
	assign alertOutZone1 = st.alert1;
	assign alertOutZone2 = st.alert2;
	assign segTens       = st.segT;
	assign segUnits      = st.segU;
	assign irq           = st.irqOut;

	// =========================================================================
	// Checks
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	chk_prot_off: assert property (
		clkEn && protDetect1 |=> !safeOutPair0A && !safeOutPair0B)
		else $error("safety pair0 on despite protection detection");

	chk_dual_split: assert property (
		clkEn && dualEff && st.areaValid && protDetect2 && !protDetect1
		|=> !safeOutPair1A && safeOutPair0A)
		else $error("dual mode pairs not following their zones");

	chk_warn_off: assert property (
		clkEn && !dualEff && warnDetect2 |=> !alertOutZone2)
		else $error("warning two on despite detection");

	chk_warn_indep: assert property (
		clkEn && !dualEff && !warnDetect1 && protDetect1
		|=> alertOutZone1)
		else $error("warning one dragged by protection zone");

	chk_comp_flag: assert property (
		clkEn && accept && compErr |=> st.irqSts[IRQ_COMP] && !st.areaValid)
		else $error("complement error not flagged");

	chk_settle_hold: assert property (
		clkEn && rawChanged ##1 clkEn |=> $stable(st.activeArea)
		&& $stable(st.areaValid))
		else $error("area changed before settling delay");

	chk_mode_limit: assert property (
		st.areaValid && st.mode != MODE_ENC |-> {1'b0, st.activeArea} < limit)
		else $error("active area above mode limit");

	chk_invalid_off: assert property (
		clkEn && !st.areaValid |=> !safeOutPair0A && !safeOutPair1A)
		else $error("safety outputs on with invalid area");

	chk_range_flag: assert property (
		clkEn && accept && !compErr && !rangeOk
		|=> st.irqSts[IRQ_RANGE] && !st.areaValid)
		else $error("out of range area accepted");

	chk_disp_dash: assert property (
		clkEn && !st.areaValid |=> segUnits == SEG_DASH)
		else $error("display not blanked for invalid area");

	cov_comp_err:  cover property (clkEn && accept && compErr);
	cov_area_chg:  cover property (clkEn && events[IRQ_AREA]);
	cov_dual_trip: cover property (clkEn && events[IRQ_PROT2]);
	cov_range_err: cover property (clkEn && events[IRQ_RANGE]);

endmodule

// ===== testbench/area_controller_model.sv
// Machine controller model driving the complementary area select pairs
`timescale 1ns/1ps

module area_controller_model (
	input  wire logic       mclk,
	input  wire logic [4:0] areaCode,
	input  wire logic [4:0] pairFault,
	output logic      [4:0] areaIn,
	output logic      [4:0] areaInInv
);
	// =========================================================================
	// Pin drivers
	// OFF counts as one, so the normal pin carries the inverse of the code.
	// A fault bit makes that pair non-complementary on purpose.
	always_ff @(posedge mclk) begin
		areaIn    <= ~areaCode;
		areaInInv <= areaCode ^ pairFault;
	end
endmodule

// ===== testbench/tb_zone_area_select_logic.sv
// Self-checking testbench for the area select and zone output block
`timescale 1ns/1ps

module tb_zone_area_select_logic;
	import zone_area_pkg::*;

	// =========================================================================
	// Signals
	localparam int CYC_MS = 4;
	// Sync, one ms of delay, and margin for accept and output stages
	localparam int SETTLE = 2 + CYC_MS + 10;
	logic        mclk       = 1'b0;
	logic        rst        = 1'b1;
	logic        clkEn      = 1'b1;
	logic [4:0]  areaCode   = 5'h00;
	logic [4:0]  pairFault  = 5'h00;
	logic        protDet1   = 1'b0;
	logic        protDet2   = 1'b0;
	logic        warnDet1   = 1'b0;
	logic        warnDet2   = 1'b0;
	logic [4:0]  encArea    = 5'h00;
	logic [7:0]  address    = 8'h00;
	logic        read       = 1'b0;
	logic        write      = 1'b0;
	logic [31:0] writedata  = 32'h0000_0000;
	logic [3:0]  byteenable = 4'hF;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [4:0]  areaIn;
	logic [4:0]  areaInInv;
	wire  [5:0]  pins;
	logic [6:0]  segTens;
	logic [6:0]  segUnits;
	logic        irq;
	logic [31:0] seed = 32'h0000_df6b;
	logic [31:0] rd;
	int          errTotal = 0;
	int          checks = 0;

	always #20 mclk = ~mclk;

	area_controller_model u_ctl (
		.mclk(mclk), .areaCode(areaCode), .pairFault(pairFault),
		.areaIn(areaIn), .areaInInv(areaInInv));

	zone_area_select_logic #(.CYCLES_MS(CYC_MS)) u_dut (
		.mclk(mclk), .rst(rst), .clkEn(clkEn), .areaIn(areaIn),
		.areaInInv(areaInInv), .protDetect1(protDet1),
		.protDetect2(protDet2), .warnDetect1(warnDet1),
		.warnDetect2(warnDet2), .encArea(encArea), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .safeOutPair0A(pins[5]),
		.safeOutPair0B(pins[4]), .safeOutPair1A(pins[3]),
		.safeOutPair1B(pins[2]), .alertOutZone1(pins[1]),
		.alertOutZone2(pins[0]), .segTens(segTens), .segUnits(segUnits),
		.irq(irq));

	// =========================================================================
	// Helpers
	function automatic logic [4:0] rnd5();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[4:0];
	endfunction

	function automatic logic [13:0] expSeg(input logic v, input logic [5:0] n);
		if (!v)
			return {SEG_DASH, SEG_DASH};
		return {(n / 10 == 0) ? SEG_BLANK : SEG_DIGITS[n / 10],
			SEG_DIGITS[n % 10]};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errTotal++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, errTotal);
		if (errTotal == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Holds the request until waitrequest is sampled low at a rising edge
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge mclk);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= wd;
		do begin
			@(posedge mclk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		if (n >= 50)
			errTotal++;
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic setArea(input logic [4:0] c);
		@(posedge mclk);
		areaCode <= c;
		repeat (SETTLE) @(posedge mclk);
	endtask

	// Invalid area leaves the index field holding the last valid area, so it is masked
	task automatic areaCheck(input logic v, input logic d, input logic [4:0] i);
		logic [31:0] st;
		bus(1'b0, OFS_STATUS, 32'h0, st);
		if (!v)
			st[4:0] = i;
		chk(st, {16'h0, 2'b11, v, v, 2'b00, d, v, 3'b000, i});
		chk({18'h0, segTens, segUnits}, {18'h0, expSeg(v, i + 6'h01)});
	endtask

	task automatic pinCheck(input logic p1, p2, w1, w2, input logic [5:0] e);
		@(posedge mclk);
		protDet1 <= p1;
		protDet2 <= p2;
		warnDet1 <= w1;
		warnDet2 <= w2;
		repeat (3) @(posedge mclk);
		chk({26'h0, pins}, {26'h0, e});
	endtask

	// =========================================================================
	// Watchdog
	initial begin
		repeat (60000) @(posedge mclk);
		errTotal++;
		tally_and_finish();
	end

	// =========================================================================
	// Tests
	logic [2:0] ctl [5] = '{3'b001, 3'b101, 3'b010, 3'b110, 3'b100};
	logic [4:0] msk [5] = '{5'h0F, 5'h0F, 5'h03, 5'h01, 5'h1F};
	logic [4:0] c;
	logic [4:0] e;

	initial begin
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		// Alerts turn on one edge after release
		repeat (2) @(posedge mclk);
		chk({26'h0, pins}, 32'h0000_0003);
		bus(1'b0, OFS_CTRL, 32'h0, rd);
		chk(rd, 32'h0000_2000);
		bus(1'b0, OFS_DELAY, 32'h0, rd);
		chk(rd, 32'h0000_001E);
		bus(1'b0, 8'h40, 32'h0, rd);
		chk(rd, 32'h0000_0000);
		wr(OFS_DELAY, 32'h0000_0001);
		wr(OFS_IRQ_MASK, 32'h0000_0001);
		$display("test reset done");
		for (int i = 0; i < 10; i++) begin
			c = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : rnd5();
			setArea(c);
			areaCheck(1'b1, 1'b0, c);
		end
		pinCheck(1'b1, 1'b0, 1'b0, 1'b0, 6'b0000_11);
		pinCheck(1'b0, 1'b0, 1'b1, 1'b0, 6'b1111_01);
		pinCheck(1'b1, 1'b0, 1'b0, 1'b1, 6'b0000_10);
		pinCheck(1'b0, 1'b0, 1'b0, 1'b0, 6'b1111_11);
		$display("test standard done");
		for (int m = 0; m < 5; m++) begin
			wr(OFS_CTRL, {16'h0, 8'h20, 5'h0, ctl[m]});
			for (int j = 0; j < 4; j++) begin
				c = rnd5();
				setArea(c);
				areaCheck(1'b1, ctl[m][2], c & msk[m]);
			end
		end
		pinCheck(1'b0, 1'b1, 1'b1, 1'b0, 6'b1100_11);
		pinCheck(1'b1, 1'b0, 1'b0, 1'b1, 6'b0011_11);
		pinCheck(1'b0, 1'b0, 1'b0, 1'b0, 6'b1111_11);
		// Enable low freezes the outputs despite a detection
		@(posedge mclk);
		clkEn    <= 1'b0;
		protDet1 <= 1'b1;
		repeat (4) @(posedge mclk);
		chk({26'h0, pins}, 32'h0000_003F);
		clkEn <= 1'b1;
		repeat (3) @(posedge mclk);
		chk({26'h0, pins}, 32'h0000_000F);
		protDet1 <= 1'b0;
		repeat (3) @(posedge mclk);
		$display("test modes done");
		wr(OFS_CTRL, 32'h0000_0500);
		setArea(5'h05);
		areaCheck(1'b0, 1'b0, 5'h05);
		bus(1'b0, OFS_IRQ_STS, 32'h0, rd);
		chk(rd & 32'h0000_0002, 32'h0000_0002);
		setArea(5'h04);
		areaCheck(1'b1, 1'b0, 5'h04);
		wr(OFS_IRQ_STS, 32'h0000_007F);
		bus(1'b0, OFS_IRQ_STS, 32'h0, rd);
		chk(rd, 32'h0000_0000);
		$display("test range done");
		@(posedge mclk);
		pairFault <= 5'b00100;
		repeat (SETTLE) @(posedge mclk);
		areaCheck(1'b0, 1'b0, 5'h04);
		chk({31'h0, irq}, 32'h1);
		chk({26'h0, pins}, 32'h0000_0003);
		wr(OFS_IRQ_MASK, 32'h0000_0000);
		repeat (3) @(posedge mclk);
		chk({31'h0, irq}, 32'h0);
		wr(OFS_IRQ_MASK, 32'h0000_0001);
		repeat (3) @(posedge mclk);
		chk({31'h0, irq}, 32'h1);
		pairFault <= 5'b00000;
		repeat (SETTLE) @(posedge mclk);
		wr(OFS_IRQ_STS, 32'h0000_007F);
		repeat (3) @(posedge mclk);
		chk({31'h0, irq}, 32'h0);
		areaCheck(1'b1, 1'b0, 5'h04);
		$display("test complement done");
		wr(OFS_CTRL, 32'h0000_2003);
		wr(OFS_PAT_LO, 32'h0000_0002);
		wr(OFS_PAT_LO + 8'h04, 32'h0000_0301);
		wr(OFS_PAT_LO + 8'h08, 32'h0000_0701);
		wr(OFS_PAT_LO + 8'h0C, 32'h0000_0000);
		bus(1'b0, OFS_PAT_LO + 8'h04, 32'h0, rd);
		chk(rd, 32'h0000_0301);
		for (int p = 0; p < 4; p++) begin
			e = rnd5();
			@(posedge mclk);
			encArea <= e;
			setArea({rnd5() & 5'h18} | 5'(p));
			areaCheck(p < 2, 1'b0, (p == 0) ? e : 5'h03);
		end
		$display("test encoder done");
		tally_and_finish();
	end
endmodule
